// ===== hdl/lbc_bypass_ctrl.v
`timescale 1ns/10ps
`include "lbc_consts.vh"

module lbc_bypass_ctrl #(
    parameter TICK_CYCLES = `LBC_SECOND_NS / `LBC_CLK_PERIOD_NS
) (
    input  wire                    core_clk,
    input  wire                    rst,
    input  wire                    scl_in,
    input  wire                    sda_in,
    output reg                     sda_out,
    output reg                     sda_oe,
    input  wire                    sys_power_on,
    output reg  [`LBC_SEG_MSB:0]   relay_close
);

    localparam [8:0] ST_IDLE      = 9'h001;
    localparam [8:0] ST_ADDR      = 9'h002;
    localparam [8:0] ST_ACK_ADDR  = 9'h004;
    localparam [8:0] ST_OFFSET    = 9'h008;
    localparam [8:0] ST_ACK_OFS   = 9'h010;
    localparam [8:0] ST_WDATA     = 9'h020;
    localparam [8:0] ST_ACK_WDATA = 9'h040;
    localparam [8:0] ST_RDATA     = 9'h080;
    localparam [8:0] ST_RACK      = 9'h100;

    // three-stage samplers on every asynchronous input
    reg  [2:0]              scl_sync;
    reg  [2:0]              sda_sync;
    reg  [2:0]              pwr_sync;
    reg                     scl_f;
    reg                     sda_f;
    reg                     pwr_f;

    reg  [8:0]              state;
    reg  [3:0]              bit_cnt;
    reg  [7:0]              shift;
    reg  [7:0]              reg_ptr;
    reg                     rw_read;
    reg                     master_nack;

    reg  [7:0]              power_on_ctrl;
    reg  [`LBC_SEG_MSB:0]   power_off_segment_enable;

    reg                     wr_stb;
    reg  [7:0]              wr_data;

    wire                    timer_expired_flag;
    wire                    timer_fire;
    wire                    timer_load;
    wire [`LBC_CODE_MSB:0]  timer_code;

    wire                    scl_rise;
    wire                    scl_fall;
    wire                    bus_start;
    wire                    bus_stop;
    wire                    pwr_fall;
    wire                    next_pwr_f;
    wire                    next_scl_f;
    wire                    next_sda_f;
    wire [1:0]              bypass_mode_field;
    wire [`LBC_SEG_MSB:0]   power_on_segment_select;
    wire                    byte_done;
    wire [7:0]              rd_byte;

    // a change counts only once the last two stages agree
    function filt;
        input s2;
        input s3;
        input old;
        begin
            filt = (s2 == s3) ? s2 : old;
        end
    endfunction

    function [7:0] reg_read;
        input [7:0]               ofs;
        input                     flag;
        input [`LBC_SEG_MSB:0]    segs;
        begin
            case (ofs)
                `LBC_OFS_TIMER:
                    reg_read = {flag, 7'h00};
                `LBC_OFS_STATUS:
                    reg_read = {`LBC_FW_VERSION, segs};
                default:
                    reg_read = `LBC_RST_BYTE;
            endcase
        end
    endfunction

    assign next_scl_f = filt(scl_sync[1], scl_sync[2], scl_f);
    assign next_sda_f = filt(sda_sync[1], sda_sync[2], sda_f);
    assign next_pwr_f = filt(pwr_sync[1], pwr_sync[2], pwr_f);

    assign scl_rise  = next_scl_f && !scl_f;
    assign scl_fall  = !next_scl_f && scl_f;
    assign bus_start = scl_f && next_scl_f && sda_f && !next_sda_f;
    assign bus_stop  = scl_f && next_scl_f && !sda_f && next_sda_f;
    assign pwr_fall  = pwr_f && !next_pwr_f;
    assign byte_done = (bit_cnt == `LBC_BITS_PER_BYTE);
    // one read byte per pointer; forming it moves no state
    assign rd_byte   = reg_read(reg_ptr, timer_expired_flag, relay_close);

    assign bypass_mode_field       = power_on_ctrl[`LBC_MODE_MSB:`LBC_MODE_LSB];
    assign power_on_segment_select = power_on_ctrl[`LBC_SEG_MSB:0];

    // power loss also stops the timer
    // host writes while powered off are dropped here as in the relay block
    assign timer_load = pwr_fall || (wr_stb && pwr_f && reg_ptr == `LBC_OFS_TIMER);
    assign timer_code = pwr_fall ? `LBC_TIMER_OFF_CODE : wr_data[`LBC_CODE_MSB:0];

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            pwr_sync <= 3'h0;
            scl_f    <= 1'b1;
            sda_f    <= 1'b1;
            pwr_f    <= 1'b0;
        end else begin
            scl_sync <= {scl_sync[1:0], scl_in};
            sda_sync <= {sda_sync[1:0], sda_in};
            pwr_sync <= {pwr_sync[1:0], sys_power_on};
            scl_f    <= next_scl_f;
            sda_f    <= next_sda_f;
            pwr_f    <= next_pwr_f;
        end
    end

    lbc_bypass_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timer (
        .core_clk  (core_clk),
        .rst       (rst),
        .load      (timer_load),
        .load_code (timer_code),
        .expired   (timer_expired_flag),
        .fire      (timer_fire)
    );

    // serial slave: byte-data write, offset then data, and byte read
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state       <= ST_IDLE;
            bit_cnt     <= 4'h0;
            shift       <= `LBC_RST_BYTE;
            reg_ptr     <= `LBC_RST_BYTE;
            rw_read     <= 1'b0;
            master_nack <= 1'b0;
            sda_out     <= 1'b0;
            sda_oe      <= 1'b0;
            wr_stb      <= 1'b0;
            wr_data     <= `LBC_RST_BYTE;
        end else begin
            wr_stb <= 1'b0;
            if (bus_start) begin
                state   <= ST_ADDR;
                bit_cnt <= 4'h0;
                sda_oe  <= 1'b0;
            end else if (bus_stop) begin
                state  <= ST_IDLE;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                case (state)
                    ST_ADDR, ST_OFFSET, ST_WDATA: begin
                        shift   <= {shift[6:0], sda_f};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    ST_RDATA: begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    ST_RACK: begin
                        master_nack <= sda_f;
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall) begin
                case (state)
                    ST_ADDR: begin
                        if (byte_done && shift[7:1] == `LBC_SLAVE_ADDR) begin
                            rw_read <= shift[0];
                            sda_oe  <= 1'b1;
                            state   <= ST_ACK_ADDR;
                        end else if (byte_done) begin
                            state <= ST_IDLE;
                        end
                    end
                    ST_ACK_ADDR: begin
                        bit_cnt <= 4'h0;
                        if (rw_read) begin
                            // reads never touch timer or relays
                            shift  <= rd_byte;
                            sda_oe <= !rd_byte[7];
                            state  <= ST_RDATA;
                        end else begin
                            sda_oe <= 1'b0;
                            state  <= ST_OFFSET;
                        end
                    end
                    ST_OFFSET: begin
                        if (byte_done) begin
                            reg_ptr <= shift;
                            sda_oe  <= 1'b1;
                            state   <= ST_ACK_OFS;
                        end
                    end
                    ST_ACK_OFS, ST_ACK_WDATA: begin
                        sda_oe  <= 1'b0;
                        bit_cnt <= 4'h0;
                        state   <= ST_WDATA;
                    end
                    ST_WDATA: begin
                        if (byte_done) begin
                            wr_stb  <= 1'b1;
                            wr_data <= shift;
                            sda_oe  <= 1'b1;
                            state   <= ST_ACK_WDATA;
                        end
                    end
                    ST_RDATA: begin
                        if (byte_done) begin
                            sda_oe <= 1'b0;
                            state  <= ST_RACK;
                        end else begin
                            sda_oe <= !shift[6];
                            shift  <= {shift[6:0], 1'b0};
                        end
                    end
                    ST_RACK: begin
                        bit_cnt <= 4'h0;
                        if (master_nack) begin
                            sda_oe <= 1'b0;
                            state  <= ST_IDLE;
                        end else begin
                            shift  <= rd_byte;
                            sda_oe <= !rd_byte[7];
                            state  <= ST_RDATA;
                        end
                    end
                    default: begin
                        sda_oe <= 1'b0;
                        state  <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // relay policy; power-off register survives power loss, rst is standby loss
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            power_on_ctrl            <= `LBC_RST_BYTE;
            power_off_segment_enable <= `LBC_RST_SEG;
            relay_close              <= `LBC_RST_SEG;
        end else if (!pwr_f || pwr_fall) begin
            power_on_ctrl <= `LBC_RST_BYTE;
            relay_close   <= power_off_segment_enable;
        end else begin
            if (wr_stb && reg_ptr == `LBC_OFS_POWER_OFF)
                power_off_segment_enable <= wr_data[`LBC_SEG_MSB:0];
            if (wr_stb && reg_ptr == `LBC_OFS_POWER_ON) begin
                power_on_ctrl <= wr_data;
                case (wr_data[`LBC_MODE_MSB:`LBC_MODE_LSB])
                    `LBC_MODE_FORCE_ON:
                        relay_close <= relay_close | wr_data[`LBC_SEG_MSB:0];
                    `LBC_MODE_FORCE_OFF:
                        relay_close <= relay_close & ~wr_data[`LBC_SEG_MSB:0];
                    default:
                        relay_close <= relay_close;
                endcase
            end else if (timer_fire && bypass_mode_field == `LBC_MODE_TIMER) begin
                // same edge as the expired flag inside the timer
                relay_close <= relay_close | power_on_segment_select;
            end
        end
    end

endmodule // lbc_bypass_ctrl

// ===== hdl/lbc_consts.vh
`ifndef LBC_CONSTS_VH
`define LBC_CONSTS_VH

// register offsets
`define LBC_OFS_TIMER       8'h12
`define LBC_OFS_POWER_ON    8'h13
`define LBC_OFS_POWER_OFF   8'h14
`define LBC_OFS_STATUS      8'h15

// field positions
`define LBC_MODE_MSB        7
`define LBC_MODE_LSB        6
`define LBC_SEG_MSB         3
`define LBC_CODE_MSB        2
`define LBC_FLAG_BIT        7
`define LBC_FWV_MSB         7
`define LBC_FWV_LSB         4

// bypass mode codes
`define LBC_MODE_UNUSED     2'h0
`define LBC_MODE_FORCE_ON   2'h1
`define LBC_MODE_FORCE_OFF  2'h2
`define LBC_MODE_TIMER      2'h3

// reset values
`define LBC_RST_BYTE        8'h00
`define LBC_RST_SEG         4'h0
`define LBC_RST_CODE        3'h0
`define LBC_TIMER_OFF_CODE  3'h0

// bus identity and version (version value arbitrary)
`define LBC_SLAVE_ADDR      7'h67
`define LBC_FW_VERSION      4'h1

// byte framing
`define LBC_BITS_PER_BYTE   4'h8

// timing
`define LBC_SECOND_NS       1000000000
`define LBC_CLK_PERIOD_NS   5
`define LBC_TICK_W          28
`define LBC_SECS_W          7

`endif

// ===== hdl/lbc_bypass_timer.v
`timescale 1ns/10ps
`include "lbc_consts.vh"

module lbc_bypass_timer #(
    parameter TICK_CYCLES = `LBC_SECOND_NS / `LBC_CLK_PERIOD_NS
) (
    input  wire                        core_clk,
    input  wire                        rst,
    input  wire                        load,
    input  wire [`LBC_CODE_MSB:0]      load_code,
    output reg                         expired,
    output wire                        fire
);

    localparam integer           TICK_LAST_I = TICK_CYCLES - 1;
    localparam [`LBC_TICK_W-1:0] TICK_LAST   = TICK_LAST_I[`LBC_TICK_W-1:0];
    localparam [`LBC_SECS_W-1:0] ONE_SEC   = 7'h01;

    reg  [`LBC_CODE_MSB:0]   code;
    reg  [`LBC_TICK_W-1:0]   tick_cnt;
    reg  [`LBC_SECS_W-1:0]   secs_left;
    wire                     active;
    wire                     tick;

    // code n gives 2^(n-1) seconds; code 0 turns the timer off
    function [`LBC_SECS_W-1:0] timeout_secs;
        input [`LBC_CODE_MSB:0] c;
        begin
            if (c == `LBC_TIMER_OFF_CODE)
                timeout_secs = {`LBC_SECS_W{1'b0}};
            else
                timeout_secs = ONE_SEC << (c - 3'h1);
        end
    endfunction

    assign active = (code != `LBC_TIMER_OFF_CODE);
    assign tick   = (tick_cnt == TICK_LAST);
    assign fire   = active && !expired && tick && (secs_left == ONE_SEC);

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            code      <= `LBC_RST_CODE;
            tick_cnt  <= {`LBC_TICK_W{1'b0}};
            secs_left <= {`LBC_SECS_W{1'b0}};
            expired   <= 1'b0;
        end else if (load) begin
            // any write restarts the full period
            code      <= load_code;
            tick_cnt  <= {`LBC_TICK_W{1'b0}};
            secs_left <= timeout_secs(load_code);
            // an expiry on the refresh edge still sets the flag, as relays close then
            expired   <= fire;
        end else if (active && !expired) begin
            tick_cnt <= tick ? {`LBC_TICK_W{1'b0}} : tick_cnt + 28'h0000001;
            if (tick)
                secs_left <= secs_left - ONE_SEC;
            if (fire)
                expired <= 1'b1;
        end
    end

endmodule // lbc_bypass_timer

// ===== verif/lbc_bypass_ctrl_checker.sv
`timescale 1ns/10ps
`include "lbc_consts.vh"

module lbc_bypass_ctrl_checker #(
    parameter TICK_CYCLES = 20
) (
    input wire                  core_clk,
    input wire                  rst,
    input wire                  scl_in,
    input wire                  sda_in,
    input wire                  sda_out,
    input wire                  sda_oe,
    input wire                  sys_power_on,
    input wire [`LBC_SEG_MSB:0] relay_close
);
    logic [3:0] off_cnt;
    logic [5:0] hi_cnt;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // saturating run lengths of power-off and of bus clock high
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            off_cnt <= 4'h0;
            hi_cnt  <= 6'h00;
        end else begin
            off_cnt <= sys_power_on ? 4'h0 : ((off_cnt == 4'hF) ? off_cnt : off_cnt + 4'h1);
            hi_cnt  <= !scl_in ? 6'h00 : ((hi_cnt == 6'h3F) ? hi_cnt : hi_cnt + 6'h01);
        end
    end

    a_sda_out_low: assert property (sda_out == 1'b0)
        else $error("sda_out not low");
    a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("sda_oe changed while bus clock high");
    a_reset_clear: assert property ($fell(rst) |-> relay_close == 4'h0 && !sda_oe)
        else $error("outputs not clear after reset");
    a_idle_release: assert property (hi_cnt > 6'h28 |-> !sda_oe)
        else $error("data line held on idle bus");
    a_off_hold: assert property (off_cnt == 4'hF |-> $stable(relay_close))
        else $error("relays moved while powered off");
    a_ack_min: assert property ($rose(sda_oe) |-> sda_oe [*8])
        else $error("acknowledge too short");
    a_oe_bounded: assert property ($rose(sda_oe) |-> ##[1:300] !sda_oe)
        else $error("data line never released");
    a_no_idle_open: assert property ((hi_cnt > 6'h28 && sys_power_on && $past(sys_power_on))
        |-> ($past(relay_close) & ~relay_close) == 4'h0)
        else $error("relay opened without a write");
endmodule // lbc_bypass_ctrl_checker

bind lbc_bypass_ctrl lbc_bypass_ctrl_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .core_clk(core_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .sys_power_on(sys_power_on), .relay_close(relay_close));

// ===== verif/lbc_host_model.sv
`timescale 1ns/10ps
`include "lbc_consts.vh"

// bus host; clock idles high between frames, data released to the pull-up
module lbc_host_model (
    output logic scl,
    output logic sda_low,
    input  wire  sda
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic start_cond;
        #31.25 sda_low = 1'b0;
        #31.25 scl = 1'b1;
        #31.25 sda_low = 1'b1;
        #31.25 scl = 1'b0;
    endtask

    task automatic stop_cond;
        #31.25 sda_low = 1'b1;
        #31.25 scl = 1'b1;
        #31.25 sda_low = 1'b0;
        #31.25;
    endtask

    // msb first, ninth bit released so the device can answer
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #31.25 sda_low = ~tx[i];
            #31.25 scl = 1'b1;
            #31.25 rx[i] = sda;
            #31.25 scl = 1'b0;
        end
        #31.25 sda_low = 1'b0;
        #31.25 scl = 1'b1;
        #31.25 ack = ~sda;
        #31.25 scl = 1'b0;
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [7:0] dat, output logic ok);
        logic [7:0] rx;
        logic       a0, a1, a2;
        start_cond();
        xfer({`LBC_SLAVE_ADDR, 1'b0}, rx, a0);
        xfer(ofs, rx, a1);
        xfer(dat, rx, a2);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask

    task automatic rd(input logic [7:0] ofs, output logic [7:0] dat, output logic ok);
        logic [7:0] rx;
        logic       a0, a1, a2, nak;
        start_cond();
        xfer({`LBC_SLAVE_ADDR, 1'b0}, rx, a0);
        xfer(ofs, rx, a1);
        start_cond();
        xfer({`LBC_SLAVE_ADDR, 1'b1}, rx, a2);
        xfer(8'hFF, dat, nak);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask

    // slot select through the first channel switch; the block must stay silent
    task automatic select_slot(input logic [7:0] chan, output logic ack);
        logic [7:0] rx;
        logic       a1;
        start_cond();
        xfer({7'h70, 1'b0}, rx, ack);
        xfer(chan, rx, a1);
        stop_cond();
    endtask

    task automatic probe(input logic [7:0] b, output logic ack);
        logic [7:0] rx;
        start_cond();
        xfer(b, rx, ack);
        stop_cond();
    endtask
endmodule // lbc_host_model

// ===== verif/tb.sv
`timescale 1ns/10ps
`include "lbc_consts.vh"

module tb;
    localparam int TICK = 2000;
    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    logic       sys_power_on = 1'b1;
    wire        scl;
    wire        sda_low;
    wire        sda;
    wire        sda_out;
    wire        sda_oe;
    wire  [3:0] relay_close;
    int         mismatches = 0;
    int         comparisons = 0;
    logic [7:0] rdat;
    logic       ok;

    // open-drain data line with pull-up
    assign sda = (sda_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;

    always #2.5 core_clk = ~core_clk;

    lbc_bypass_ctrl #(.TICK_CYCLES(TICK)) i_dut (
        .core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .sys_power_on(sys_power_on), .relay_close(relay_close));
    lbc_host_model i_host (.scl(scl), .sda_low(sda_low), .sda(sda));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // off-edge landing keeps bus edges away from clock edges
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic relay(input logic [3:0] exp);
        chk({4'h0, relay_close}, {4'h0, exp}, "relays");
    endtask
    task automatic w(input logic [7:0] ofs, input logic [7:0] dat);
        i_host.wr(ofs, dat, ok);
        chk({7'h00, ok}, 8'h01, "write ack");
    endtask
    task automatic r(input logic [7:0] ofs);
        i_host.rd(ofs, rdat, ok);
        chk({7'h00, ok}, 8'h01, "read ack");
    endtask
    task automatic power(input logic on);
        @(posedge core_clk) sys_power_on <= on;
        cyc(20);
    endtask

    task automatic t_reset;
        i_host.select_slot(8'h01, ok);
        chk({7'h00, ok}, 8'h00, "switch address ack");
        r(`LBC_OFS_STATUS);
        chk(rdat, {`LBC_FW_VERSION, 4'h0}, "status at reset");
        i_host.probe(8'hD0, ok);
        chk({7'h00, ok}, 8'h00, "foreign address ack");
        relay(4'h0);
        $display("test reset done");
    endtask

    task automatic t_force;
        w(`LBC_OFS_POWER_ON, 8'h45);
        relay(4'h5);
        w(`LBC_OFS_POWER_ON, 8'h81);
        relay(4'h4);
        r(`LBC_OFS_POWER_ON);
        r(`LBC_OFS_POWER_OFF);
        relay(4'h4);
        w(`LBC_OFS_POWER_ON, 8'h0F);
        relay(4'h4);
        r(`LBC_OFS_STATUS);
        chk(rdat, {`LBC_FW_VERSION, 4'h4}, "status");
        $display("test force done");
    endtask

    task automatic t_timer;
        w(`LBC_OFS_POWER_ON, 8'hC3);
        relay(4'h4);
        w(`LBC_OFS_TIMER, 8'h01);
        r(`LBC_OFS_TIMER);
        chk(rdat & 8'h80, 8'h00, "flag before expiry");
        w(`LBC_OFS_TIMER, 8'h01);
        cyc(TICK - 100);
        relay(4'h4);
        cyc(110);
        relay(4'h7);
        r(`LBC_OFS_TIMER);
        chk(rdat & 8'h80, 8'h80, "flag after expiry");
        w(`LBC_OFS_POWER_ON, 8'h83);
        w(`LBC_OFS_POWER_ON, 8'hC3);
        w(`LBC_OFS_TIMER, 8'h03);
        cyc(2 * TICK);
        r(`LBC_OFS_TIMER);
        chk(rdat & 8'h80, 8'h00, "flag mid count");
        cyc(2 * TICK - 1075);
        relay(4'h4);
        cyc(110);
        relay(4'h7);
        $display("test timer done");
    endtask

    task automatic t_code0;
        w(`LBC_OFS_TIMER, 8'h00);
        w(`LBC_OFS_POWER_ON, 8'h83);
        w(`LBC_OFS_POWER_ON, 8'hC3);
        cyc(3 * TICK);
        relay(4'h4);
        r(`LBC_OFS_TIMER);
        chk(rdat & 8'h80, 8'h00, "flag with timer off");
        $display("test timer off done");
    endtask

    task automatic t_power;
        w(`LBC_OFS_POWER_OFF, 8'h0A);
        relay(4'h4);
        power(1'b0);
        relay(4'hA);
        power(1'b1);
        relay(4'hA);
        w(`LBC_OFS_TIMER, 8'h01);
        cyc(TICK + 200);
        relay(4'hA);
        power(1'b0);
        relay(4'hA);
        power(1'b1);
        $display("test power done");
    endtask

    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        // tests take about 36k clocks; this allows some 60k before giving up
        #300_000;
        mismatches++;
        $display("[FAIL] %0t ns: run did not finish", $time);
        final_report();
    end

    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        cyc(12);
        t_reset();
        t_force();
        t_timer();
        t_code0();
        t_power();
        final_report();
    end
endmodule // tb
